// *** rtl/avm_pkg.sv ***
// Purpose: Shared constants and carriers for the audio volume and mute block.
// Assumes: One 25 MHz clock; registers reached by a plain word port.
// Notes: Gain codes are 7 bits, half a decibel per code.
// Summary of operation
// RQ1: Playback gain code is linear, 7Fh is 0 dB, 00h is -63.5 dB.
// RQ2: Playback mute ramps gain to lowest, then feeds only zero samples.
// RQ3: Mute keeps the stored gain code; unmute returns to it.
// RQ4: Playback unmute stops zero forcing and ramps gain back up.
// RQ5: Playback register bit 15 is left mute, bits 14..8 left gain.
// RQ6: Playback register bit 7 is right mute, bits 6..0 right gain.
// RQ7: Playback mutes reset to 1 and gains reset to 7Fh.
// RQ8: Bypass code 7Fh is +12 dB, 67h is 0 dB, 20h is -35.5 dB.
// RQ9: Bypass codes below 20h act like the bypass mute bit.
// RQ10: Bypass mute ramps down then silences; clearing reverses the ramp.
// RQ11: Bypass register packs left mute, left gain, right mute, right gain.
// RQ12: Bypass mutes reset to 1 and gains reset to 67h.
// RQ13: Each bypass mute gates its line input toward line and headphone.
// RQ14: One soft step every 20 us, or every 40 us at half rate.
// RQ15: Read-only ramp done flag is 0 while ramping, 1 otherwise; the code also drops it in the cycle after any write.
// RQ16: Gain changes step one code per tick toward the new target.
package avm_pkg;
  localparam logic [1:0] PLAY_ADDR = 2'h2;
  localparam logic [1:0] PASS_ADDR = 2'h3;
  localparam int MUTE_HI = 15;
  localparam int GAIN_HI_LSB = 8;
  localparam int MUTE_LO = 7;
  localparam int GAIN_LO_LSB = 0;
  localparam logic [6:0] PLAY_GAIN_RST = 7'h7F;
  localparam logic [6:0] PLAY_FLOOR = 7'h00;
  localparam logic [6:0] PASS_GAIN_RST = 7'h67;
  localparam logic [6:0] PASS_FLOOR = 7'h1F;
  localparam logic [6:0] PASS_MIN_CODE = 7'h20;
  localparam int CLK_HZ = 25000000;
  localparam int STEP_US = 20;
  localparam int STEP_CYC = (CLK_HZ / 1000000) * STEP_US;

  typedef struct packed {
    logic silence;
    logic [6:0] gain;
  } avm_chan_s;

  typedef struct packed {
    avm_chan_s left;
    avm_chan_s right;
  } avm_pair_s;
endpackage : avm_pkg

// *** rtl/avm_tick.sv ***
// Purpose: Soft-step tick divider.
// Assumes: Runs on sys_clk.
// Notes: Half rate skips every other tick so both rates share one counter.
`timescale 1ns/1ps
`default_nettype none
module avm_tick #(
  parameter int CYC = avm_pkg::STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic half_rate,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic odd;
    logic tick;
  } avm_tick_s;
  avm_tick_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == 16'(CYC - 1)) begin
      st_next.cnt = 16'h0000;
      st_next.odd = ~st_reg.odd;
      st_next.tick = ~half_rate | st_reg.odd; // RQ14
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule : avm_tick
`default_nettype wire

// *** rtl/avm_ramp.sv ***
// Purpose: One channel's gain ramp toward a target or toward its floor.
// Assumes: Tick is a one-cycle pulse.
// Notes: The path is silenced only once the applied gain sits at the floor.
`timescale 1ns/1ps
`default_nettype none
module avm_ramp (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic mute,
  input wire logic [6:0] target,
  input wire logic [6:0] floor_code,
  output logic [6:0] applied,
  output logic silent,
  output logic busy
);
  typedef struct packed {
    logic [6:0] gain;
    logic silent;
  } avm_ramp_s;
  avm_ramp_s st_reg, st_next;
  logic [6:0] aim;

  always_comb begin
    aim = mute ? floor_code : target; // RQ3
    st_next = st_reg;
    if (tick) begin
      if (st_reg.gain < aim) begin
        st_next.gain = st_reg.gain + 7'h01; // RQ16
      end else if (st_reg.gain > aim) begin
        st_next.gain = st_reg.gain - 7'h01; // RQ16
      end
    end
    st_next.silent = mute && (st_reg.gain == floor_code); // RQ2
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign applied = st_reg.gain;
  assign silent = st_reg.silent;
  assign busy = (st_reg.gain != aim) || (mute != st_reg.silent);
endmodule : avm_ramp
`default_nettype wire

// *** rtl/avm_top.sv ***
// Purpose: Playback and bypass gain registers with soft-stepped mute.
// Assumes: Register port writes and reads a whole 16-bit word.
// Notes: Applied gains start at 00h; playback ramps up once unmuted, bypass first climbs to its 1Fh floor while muted.
`timescale 1ns/1ps
`default_nettype none
module avm_top #(
  parameter int STEP_CYCLES = avm_pkg::STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic ramp_half_rate_sel,
  output logic ramp_done_flag,
  input wire logic [19:0] play_left_in,
  input wire logic [19:0] play_right_in,
  output logic [19:0] play_left_out,
  output logic [19:0] play_right_out,
  output logic [6:0] play_left_gain_applied,
  output logic [6:0] play_right_gain_applied,
  output logic [6:0] pass_left_gain_applied,
  output logic [6:0] pass_right_gain_applied,
  output logic left_line_pass_en,
  output logic right_line_pass_en
);
  typedef struct packed {
    avm_pkg::avm_pair_s play;
    avm_pkg::avm_pair_s pass;
    logic [15:0] rdata;
    logic done;
    logic [19:0] pl_out;
    logic [19:0] pr_out;
    logic [6:0] g0;
    logic [6:0] g1;
    logic [6:0] g2;
    logic [6:0] g3;
    logic en_l;
    logic en_r;
  } avm_top_s;
  avm_top_s st_reg, st_next;

  logic tick;
  logic [3:0] mute_v;
  logic [6:0] tgt [4];
  logic [6:0] flr [4];
  logic [6:0] app [4];
  logic [3:0] sil;
  logic [3:0] bsy;

  function automatic logic [15:0] pack_pair(input avm_pkg::avm_pair_s p);
    pack_pair = {p.left.silence, p.left.gain, p.right.silence, p.right.gain};
  endfunction : pack_pair

  function automatic avm_pkg::avm_pair_s unpack_pair(input logic [15:0] w);
    unpack_pair.left.silence = w[avm_pkg::MUTE_HI];
    unpack_pair.left.gain = w[avm_pkg::GAIN_HI_LSB +: 7];
    unpack_pair.right.silence = w[avm_pkg::MUTE_LO];
    unpack_pair.right.gain = w[avm_pkg::GAIN_LO_LSB +: 7];
  endfunction : unpack_pair

  function automatic logic [19:0] scale(input logic [19:0] s,
                                        input logic [6:0] g);
    logic signed [27:0] p;
    p = $signed(s) * $signed({1'b0, g, 1'b0});
    scale = p[27:8];
  endfunction : scale

  avm_tick #(
    .CYC(STEP_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .half_rate(ramp_half_rate_sel),
    .tick(tick)
  );

  always_comb begin
    mute_v[0] = st_reg.play.left.silence;
    mute_v[1] = st_reg.play.right.silence;
    mute_v[2] = st_reg.pass.left.silence ||
                (st_reg.pass.left.gain < avm_pkg::PASS_MIN_CODE); // RQ9
    mute_v[3] = st_reg.pass.right.silence ||
                (st_reg.pass.right.gain < avm_pkg::PASS_MIN_CODE); // RQ9
    tgt[0] = st_reg.play.left.gain;
    tgt[1] = st_reg.play.right.gain;
    tgt[2] = st_reg.pass.left.gain;
    tgt[3] = st_reg.pass.right.gain;
    flr[0] = avm_pkg::PLAY_FLOOR; // RQ1
    flr[1] = avm_pkg::PLAY_FLOOR;
    flr[2] = avm_pkg::PASS_FLOOR; // RQ8
    flr[3] = avm_pkg::PASS_FLOOR;
  end

  for (genvar i = 0; i < 4; i++) begin : g_ch
    avm_ramp u_ramp (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick),
      .mute(mute_v[i]),
      .target(tgt[i]),
      .floor_code(flr[i]),
      .applied(app[i]),
      .silent(sil[i]),
      .busy(bsy[i])
    );
  end

  always_comb begin
    st_next = st_reg;
    if (reg_wr && reg_addr == avm_pkg::PLAY_ADDR) begin
      st_next.play = unpack_pair(reg_wdata); // RQ5 RQ6
    end
    if (reg_wr && reg_addr == avm_pkg::PASS_ADDR) begin
      st_next.pass = unpack_pair(reg_wdata); // RQ11
    end
    // Read data holds between reads; an unmapped read returns zero.
    st_next.rdata = st_reg.rdata;
    if (reg_rd && reg_addr == avm_pkg::PLAY_ADDR) begin
      st_next.rdata = pack_pair(st_reg.play);
    end else if (reg_rd && reg_addr == avm_pkg::PASS_ADDR) begin
      st_next.rdata = pack_pair(st_reg.pass);
    end else if (reg_rd) begin
      st_next.rdata = 16'h0000;
    end
    // A write may start a ramp next cycle, so the flag also drops on writes.
    st_next.done = ~(|bsy) & ~reg_wr; // RQ15
    // Zero samples once muted ramp reaches floor; silence wins over scaling.
    st_next.pl_out = sil[0] ? 20'h00000 : scale(play_left_in, app[0]); // RQ2 RQ4
    st_next.pr_out = sil[1] ? 20'h00000 : scale(play_right_in, app[1]);
    st_next.g0 = app[0];
    st_next.g1 = app[1];
    st_next.g2 = app[2];
    st_next.g3 = app[3];
    st_next.en_l = ~sil[2]; // RQ10 RQ13
    st_next.en_r = ~sil[3]; // RQ13
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.play.left.silence <= 1'b1; // RQ7
      st_reg.play.left.gain <= avm_pkg::PLAY_GAIN_RST;
      st_reg.play.right.silence <= 1'b1;
      st_reg.play.right.gain <= avm_pkg::PLAY_GAIN_RST;
      st_reg.pass.left.silence <= 1'b1; // RQ12
      st_reg.pass.left.gain <= avm_pkg::PASS_GAIN_RST;
      st_reg.pass.right.silence <= 1'b1;
      st_reg.pass.right.gain <= avm_pkg::PASS_GAIN_RST;
      st_reg.done <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign ramp_done_flag = st_reg.done;
  assign play_left_out = st_reg.pl_out;
  assign play_right_out = st_reg.pr_out;
  assign play_left_gain_applied = st_reg.g0;
  assign play_right_gain_applied = st_reg.g1;
  assign pass_left_gain_applied = st_reg.g2;
  assign pass_right_gain_applied = st_reg.g3;
  assign left_line_pass_en = st_reg.en_l;
  assign right_line_pass_en = st_reg.en_r;
endmodule : avm_top
`default_nettype wire

// *** tb/avm_properties.sv ***
// Purpose: Port checks for the volume and mute block.
// Assumes: One clock domain; bound into avm_top.
// Notes: The idle bound allows one half-rate step plus slack.
`timescale 1ns/1ps
`default_nettype none
module avm_properties #(
  parameter int STEP_CYCLES = avm_pkg::STEP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic ramp_done_flag,
  input wire logic [19:0] play_left_out,
  input wire logic [6:0] play_left_gain_applied,
  input wire logic [6:0] play_right_gain_applied,
  input wire logic [6:0] pass_left_gain_applied,
  input wire logic [6:0] pass_right_gain_applied,
  input wire logic left_line_pass_en,
  input wire logic right_line_pass_en
);
  logic [15:0] gap_reg;
  logic [15:0] quiet_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A write restarts the idle count, since its ramp waits for a tick.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= 16'hFFFF;
      quiet_reg <= 16'h0000;
    end else begin
      gap_reg <= $changed(play_left_gain_applied) ? 16'h0000 : gap_reg + 1'b1;
      quiet_reg <= ($changed({play_left_gain_applied, play_right_gain_applied,
        pass_left_gain_applied, pass_right_gain_applied}) || reg_wr) ?
        16'h0000 : quiet_reg + 1'b1;
    end
  end
  sequence wr_then_rd;
    reg_wr && reg_addr[1] ##1 reg_rd && reg_addr == $past(reg_addr);
  endsequence
  step_one_code_a: assert property ($changed(play_left_gain_applied) |->
    7'(play_left_gain_applied - $past(play_left_gain_applied)) inside
    {7'h01, 7'h7F})
    else $error("applied gain jumped");
  step_spacing_a: assert property ($changed(play_left_gain_applied) |->
    gap_reg >= STEP_CYCLES - 1) else $error("gain stepped too soon");
  done_when_idle_a: assert property (quiet_reg > 2 * STEP_CYCLES + 4 |->
    ramp_done_flag) else $error("done flag low while idle");
  write_clears_done_a: assert property (reg_wr |=> !ramp_done_flag)
    else $error("done flag high after write");
  readback_word_a: assert property (wr_then_rd |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("readback differs");
  // A closed path must sit at the floor: silencing waits for the ramp.
  pass_gate_left_a: assert property (!left_line_pass_en |->
    pass_left_gain_applied <= 7'h1F) else $error("left bypass shut early");
  pass_gate_right_a: assert property (!right_line_pass_en |->
    pass_right_gain_applied <= 7'h1F) else $error("right bypass shut early");
  play_zero_a: assert property ((play_left_gain_applied == 7'h00) [*3] |->
    play_left_out == 20'h00000) else $error("samples pass at floor");
endmodule : avm_properties
bind avm_top avm_properties #(.STEP_CYCLES(STEP_CYCLES)) chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ramp_done_flag(ramp_done_flag), .play_left_out(play_left_out),
  .play_left_gain_applied(play_left_gain_applied),
  .play_right_gain_applied(play_right_gain_applied),
  .pass_left_gain_applied(pass_left_gain_applied),
  .pass_right_gain_applied(pass_right_gain_applied),
  .left_line_pass_en(left_line_pass_en),
  .right_line_pass_en(right_line_pass_en));
`default_nettype wire

// *** tb/avm_top_tb.sv ***
// Purpose: Self-checking bench for the volume and mute block.
// Assumes: A short step count so that ramps end quickly.
// Notes: Samples of 128 make the scaled output equal the gain code.
`timescale 1ns/1ps
`default_nettype none
module avm_top_tb;
  localparam int SC = 4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic half = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [19:0] smp = 20'h00080;
  logic [19:0] pl_out;
  logic [19:0] pr_out;
  logic [6:0] pla, pra, psl, psr, gl, gr, o_l, o_r;
  logic done, len, ren;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  avm_top #(.STEP_CYCLES(SC)) dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ramp_half_rate_sel(half), .ramp_done_flag(done),
    .play_left_in(smp), .play_right_in(smp), .play_left_out(pl_out),
    .play_right_out(pr_out), .play_left_gain_applied(pla),
    .play_right_gain_applied(pra), .pass_left_gain_applied(psl),
    .pass_right_gain_applied(psr), .left_line_pass_en(len),
    .right_line_pass_en(ren));
  initial forever #20 sys_clk = ~sys_clk;
  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr
  // Called at a falling edge, so a read may follow a write directly.
  task automatic rdc(input logic [1:0] a, input logic [15:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    chk(20'(reg_rdata), 20'(exp));
  endtask : rdc
  task automatic settle(output int k);
    k = 0;
    repeat (2) @(negedge sys_clk);
    while (done !== 1'b1 && k < 5000) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (3) @(negedge sys_clk);
  endtask : settle
  function automatic logic ramp_ok(int k, int a, int b, int c, int d, int p);
    int s = (a > b) ? a - b : b - a;
    int t = (c > d) ? c - d : d - c;
    s = (s > t) ? s : t;
    return k >= (s - 1) * p - 3 && k <= (s + 1) * p + 3;
  endfunction : ramp_ok
  initial begin
    void'($urandom(32'hB90851F8));
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    rdc(2'h2, 16'hFFFF);
    rdc(2'h3, 16'hE7E7);
    rdc(2'h0, 16'h0000);
    settle(n);
    o_l = 7'h00;
    o_r = 7'h00;
    for (int i = 0; i < 4; i++) begin
      gl = (i == 0) ? 7'h7F : 7'($urandom_range(1, 127));
      gr = (i == 0) ? 7'h00 : 7'($urandom);
      half = i[0];
      wr(2'h2, {1'b0, gl, 1'b0, gr});
      settle(n);
      chk(20'(ramp_ok(n, gl, o_l, gr, o_r, SC << half)), 20'h1);
      chk(20'({pla, pra}), 20'({gl, gr}));
      chk(pl_out, 20'(gl));
      chk(pr_out, 20'(gr));
      rdc(2'h2, {1'b0, gl, 1'b0, gr});
      o_l = gl;
      o_r = gr;
    end
    half = 1'b1;
    wr(2'h2, {1'b1, o_l, 1'b1, o_r});
    settle(n);
    chk(20'(ramp_ok(n, 0, o_l, 0, o_r, 2 * SC)), 20'h1);
    chk({pl_out[12:0], pla}, 20'h00000);
    rdc(2'h2, {1'b1, o_l, 1'b1, o_r});
    wr(2'h2, {1'b0, o_l, 1'b1, o_r});
    settle(n);
    chk({pl_out[12:0], pra}, 20'(o_l) << 7);
    half = 1'b0;
    wr(2'h3, 16'h4010);
    settle(n);
    chk(20'({len, ren, psl, psr}), 20'({2'b10, 7'h40, 7'h1F}));
    wr(2'h3, 16'hC020);
    rdc(2'h3, 16'hC020);
    settle(n);
    chk(20'({len, ren, psl, psr}), 20'({2'b01, 7'h1F, 7'h20}));
    wr(2'h1, 16'($urandom));
    rdc(2'h2, {1'b0, o_l, 1'b1, o_r});
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    rdc(2'h2, 16'hFFFF);
    settle(n);
    tally_and_finish();
  end
endmodule : avm_top_tb
`default_nettype wire
